// ===== include/irfb_defines.vh
// Register map and field positions of the interrupt request flag bank.
// Assumes APB with 32-bit data and word-aligned byte addresses.
`ifndef IRFB_DEFINES_VH
`define IRFB_DEFINES_VH

`define IRFB_ADDR_W         8
`define IRFB_OFS_MON        8'h08
`define IRFB_OFS_SER1       8'h0C
`define IRFB_OFS_SER2       8'h10
`define IRFB_OFS_CAPC       8'h14
`define IRFB_OFS_CLR_MON    8'h28
`define IRFB_OFS_CLR_SER1   8'h2C
`define IRFB_OFS_CLR_SER2   8'h30
`define IRFB_OFS_CLR_CAPC   8'h34
`define IRFB_RST_VAL        32'h0000_0000

`define IRFB_MON_BASE       4
`define IRFB_MON4_RISE      6
`define IRFB_MON4_FALL      7
`define IRFB_MON5_RISE      8
`define IRFB_MON5_FALL      9
`define IRFB_MON_MASK       32'h0000_03C0

`define IRFB_SER_ERR        0
`define IRFB_SER_TX         1
`define IRFB_SER_RX         2
`define IRFB_SER_MASK       32'h0000_0007

`define IRFB_CC_REQ0        0
`define IRFB_CC_REQ1        4
`define IRFB_CC_REQ2        16
`define IRFB_CC_REQ3        20
`define IRFB_CC_MASK        32'h0011_0011

`endif

// ===== logic/irfb_flag_bank.v
// Interrupt request flag bank: sticky event flags with APB access.
// Assumes peripheral events are one-cycle pulses on ref_clk_i and
// monitor inputs come from pins, asynchronous to ref_clk_i.
//
// Design decision made here: the APB register port.
`timescale 1ns/10ps
`include "irfb_defines.vh"

module irfb_flag_bank #(
  parameter SYNC_STAGES = 3
) (
  // Clock and reset
  input  wire        ref_clk_i,
  input  wire        rst_i,
  // APB slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [31:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  // Monitor pins 4 and 5, asynchronous
  input  wire [1:0]  monitor_pin_i,
  // Serial channel events, one-cycle pulses
  input  wire        ser1_err_i,
  input  wire        ser1_tx_i,
  input  wire        ser1_rx_i,
  input  wire        ser2_err_i,
  input  wire        ser2_tx_i,
  input  wire        ser2_rx_i,
  // Capture/compare service requests, one-cycle pulses
  input  wire [3:0]  capcomp_req_i,
  // Flag images
  output reg  [31:0] monitor_edge_flags_o,
  output reg  [31:0] serial_ch1_event_flags_o,
  output reg  [31:0] serial_ch2_event_flags_o,
  output reg  [31:0] capcomp_service_flags_o
);

  reg  [SYNC_STAGES-1:0] mon_sync_ff [0:1];
  reg  [1:0]  mon_level_ff;
  reg  [1:0]  mon_rise;
  reg  [1:0]  mon_fall;
  reg  [31:0] mon_flags_ff;
  reg  [31:0] ser1_flags_ff;
  reg  [31:0] ser2_flags_ff;
  reg  [31:0] capc_flags_ff;
  reg  [31:0] nxt_mon;
  reg  [31:0] nxt_ser1;
  reg  [31:0] nxt_ser2;
  reg  [31:0] nxt_capc;
  reg  [31:0] set_mon;
  reg  [31:0] set_ser1;
  reg  [31:0] set_ser2;
  reg  [31:0] set_capc;
  reg  [31:0] nxt_rdata;
  reg         nxt_err;
  reg         acc_ff;

  wire [7:0]  addr;
  wire        wr_take;
  wire        rd_take;

  assign addr    = paddr_i[`IRFB_ADDR_W-1:0];
  // One wait state: the access phase ends in its second cycle
  assign wr_take = psel_i & penable_i & ~acc_ff & pwrite_i;
  assign rd_take = psel_i & penable_i & ~acc_ff & ~pwrite_i;

  // Pin synchronisers; edge logic reads only stages 2 and 3
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_mon
      always @(posedge ref_clk_i) begin
        if (rst_i) begin
          mon_sync_ff[g]  <= {SYNC_STAGES{1'b0}};
          mon_level_ff[g] <= 1'b0;
        end else begin
          mon_sync_ff[g] <= {mon_sync_ff[g][SYNC_STAGES-2:0],
                             monitor_pin_i[g]};
          if (mon_sync_ff[g][SYNC_STAGES-1] == mon_sync_ff[g][SYNC_STAGES-2])
            mon_level_ff[g] <= mon_sync_ff[g][SYNC_STAGES-1];
        end
      end
      always @* begin
        // Separate rise and fall pulses of one cycle
        mon_rise[g] = ~mon_level_ff[g] & mon_sync_ff[g][SYNC_STAGES-1] &
                      mon_sync_ff[g][SYNC_STAGES-2];
        mon_fall[g] = mon_level_ff[g] & ~mon_sync_ff[g][SYNC_STAGES-1] &
                      ~mon_sync_ff[g][SYNC_STAGES-2];
      end
    end
  endgenerate

  always @* begin
    set_mon  = `IRFB_RST_VAL;
    set_ser1 = `IRFB_RST_VAL;
    set_ser2 = `IRFB_RST_VAL;
    set_capc = `IRFB_RST_VAL;
    // Bit 6 of this register is input 4 rising, kept with its pair
    set_mon[`IRFB_MON4_RISE]     = mon_rise[0];
    set_mon[`IRFB_MON4_FALL]     = mon_fall[0];
    set_mon[`IRFB_MON5_RISE]     = mon_rise[1];
    set_mon[`IRFB_MON5_FALL]     = mon_fall[1];
    set_ser1[`IRFB_SER_ERR]      = ser1_err_i;
    set_ser1[`IRFB_SER_TX]       = ser1_tx_i;
    set_ser1[`IRFB_SER_RX]       = ser1_rx_i;
    set_ser2[`IRFB_SER_ERR]      = ser2_err_i;
    set_ser2[`IRFB_SER_TX]       = ser2_tx_i;
    set_ser2[`IRFB_SER_RX]       = ser2_rx_i;
    set_capc[`IRFB_CC_REQ0]      = capcomp_req_i[0];
    set_capc[`IRFB_CC_REQ1]      = capcomp_req_i[1];
    set_capc[`IRFB_CC_REQ2]      = capcomp_req_i[2];
    set_capc[`IRFB_CC_REQ3]      = capcomp_req_i[3];
  end

  always @* begin
    nxt_mon  = mon_flags_ff;
    nxt_ser1 = ser1_flags_ff;
    nxt_ser2 = ser2_flags_ff;
    nxt_capc = capc_flags_ff;
    if (wr_take) begin
      case (addr)
        `IRFB_OFS_CLR_MON:  nxt_mon  = mon_flags_ff & ~pwdata_i;
        `IRFB_OFS_CLR_SER1: nxt_ser1 = ser1_flags_ff & ~pwdata_i;
        `IRFB_OFS_CLR_SER2: nxt_ser2 = ser2_flags_ff & ~pwdata_i;
        `IRFB_OFS_CLR_CAPC: nxt_capc = capc_flags_ff & ~pwdata_i;
        default: ;
      endcase
    end
    // Set after clear so a same-cycle event survives
    nxt_mon  = (nxt_mon  | set_mon)  & `IRFB_MON_MASK;
    nxt_ser1 = (nxt_ser1 | set_ser1) & `IRFB_SER_MASK;
    nxt_ser2 = (nxt_ser2 | set_ser2) & `IRFB_SER_MASK;
    nxt_capc = (nxt_capc | set_capc) & `IRFB_CC_MASK;
  end

  always @* begin
    nxt_rdata = `IRFB_RST_VAL;
    nxt_err   = 1'b0;
    if (rd_take | wr_take) begin
      case (addr)
        `IRFB_OFS_MON:      nxt_rdata = mon_flags_ff;
        `IRFB_OFS_SER1:     nxt_rdata = ser1_flags_ff;
        `IRFB_OFS_SER2:     nxt_rdata = ser2_flags_ff;
        `IRFB_OFS_CAPC:     nxt_rdata = capc_flags_ff;
        `IRFB_OFS_CLR_MON,
        `IRFB_OFS_CLR_SER1,
        `IRFB_OFS_CLR_SER2,
        `IRFB_OFS_CLR_CAPC: nxt_rdata = `IRFB_RST_VAL;
        default:            nxt_err   = 1'b1;
      endcase
      // Flag registers are read-only; writing them is an error
      if (wr_take && (addr == `IRFB_OFS_MON || addr == `IRFB_OFS_SER1 ||
          addr == `IRFB_OFS_SER2 || addr == `IRFB_OFS_CAPC))
        nxt_err = 1'b1;
      if (paddr_i[31:`IRFB_ADDR_W] != 24'h00_0000)
        nxt_err = 1'b1;
      if (wr_take | nxt_err)
        nxt_rdata = `IRFB_RST_VAL;
    end
  end

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      mon_flags_ff             <= `IRFB_RST_VAL;
      ser1_flags_ff            <= `IRFB_RST_VAL;
      ser2_flags_ff            <= `IRFB_RST_VAL;
      capc_flags_ff            <= `IRFB_RST_VAL;
      monitor_edge_flags_o     <= `IRFB_RST_VAL;
      serial_ch1_event_flags_o <= `IRFB_RST_VAL;
      serial_ch2_event_flags_o <= `IRFB_RST_VAL;
      capcomp_service_flags_o  <= `IRFB_RST_VAL;
      acc_ff                   <= 1'b0;
      pready_o                 <= 1'b0;
      pslverr_o                <= 1'b0;
      prdata_o                 <= `IRFB_RST_VAL;
    end else begin
      mon_flags_ff             <= nxt_mon;
      ser1_flags_ff            <= nxt_ser1;
      ser2_flags_ff            <= nxt_ser2;
      capc_flags_ff            <= nxt_capc;
      monitor_edge_flags_o     <= nxt_mon;
      serial_ch1_event_flags_o <= nxt_ser1;
      serial_ch2_event_flags_o <= nxt_ser2;
      capcomp_service_flags_o  <= nxt_capc;
      acc_ff                   <= psel_i & penable_i & ~acc_ff;
      pready_o                 <= psel_i & penable_i & ~acc_ff;
      pslverr_o                <= nxt_err;
      prdata_o                 <= nxt_rdata;
    end
  end

endmodule

// ===== dv/irfb_flag_bank_sva.sv
// Checker for the flag bank; sees only the top module's ports.
// Assumes an APB master that holds each request until pready_o.
`timescale 1ns/10ps
module irfb_flag_bank_sva (
  input wire logic        ref_clk_i, rst_i, psel_i, penable_i, pwrite_i,
  input wire logic        pready_o, ser1_err_i, ser1_tx_i, ser2_rx_i,
  input wire logic [31:0] paddr_i, pwdata_i, monitor_edge_flags_o,
  input wire logic [31:0] serial_ch1_event_flags_o, serial_ch2_event_flags_o,
  input wire logic [31:0] capcomp_service_flags_o,
  input wire logic [3:0]  capcomp_req_i,
  input wire logic [1:0]  monitor_pin_i
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  ser1_tx_a: assert property (
    ser1_tx_i |=> serial_ch1_event_flags_o[1]) else $error("tx flag lost");
  ser1_err_a: assert property (
    ser1_err_i |=> serial_ch1_event_flags_o[0]) else $error("err flag lost");
  ser2_rx_a: assert property (
    ser2_rx_i |=> serial_ch2_event_flags_o[2]) else $error("rx flag lost");
  cc_req3_a: assert property (
    capcomp_req_i[3] |=> capcomp_service_flags_o[20]) else $error("cc3 lost");
  // The serial channel 1 receive flag (bit 2) may only drop by a clear write aimed at its bit
  sticky_clr_a: assert property ($fell(serial_ch1_event_flags_o[2]) |->
    $past(psel_i && penable_i && pwrite_i && paddr_i == 32'h2C && pwdata_i[2]))
    else $error("flag dropped without clear");
  rst_zero_a: assert property (disable iff (1'b0) rst_i |=>
    (serial_ch1_event_flags_o | serial_ch2_event_flags_o |
     capcomp_service_flags_o | monitor_edge_flags_o) == 32'h0)
    else $error("flags not zero after reset");
  mon5_rise_a: assert property (
    $rose(monitor_pin_i[1]) |-> ##[1:6] monitor_edge_flags_o[8])
    else $error("rise flag missing");
  resv_zero_a: assert property (
    (capcomp_service_flags_o & ~32'h0011_0011) == 32'h0 &&
    monitor_edge_flags_o[31:10] == 22'h0) else $error("reserved bit set");
endmodule
bind irfb_flag_bank irfb_flag_bank_sva u_sva (.*);

// ===== dv/irfb_evt_src.sv
// Peripheral event sources: each fire request becomes one-cycle pulses, one every other cycle while held.
// Assumes fire_i is driven just after a rising edge.
`timescale 1ns/10ps
module irfb_evt_src (
  input  wire logic       ref_clk_i,
  input  wire logic [9:0] fire_i,
  output logic      [9:0] pulse_o
);
  initial pulse_o = 10'h000;
  // A held request still yields single pulses
  always @(posedge ref_clk_i) pulse_o <= fire_i & ~pulse_o;
endmodule

// ===== dv/irfb_flag_bank_tb.sv
// Testbench: APB master, event source and pin stimulus for the flag bank.
// Assumes one clock, synchronous reset and 3-stage pin synchronisers.
`timescale 1ns/10ps
module irfb_flag_bank_tb;
  logic        ref_clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o;
  logic        pslverr_o, ser1_err_i, ser1_tx_i, ser1_rx_i, e;
  logic        ser2_err_i, ser2_tx_i, ser2_rx_i;
  logic [31:0] paddr_i, pwdata_i, prdata_o, r, monitor_edge_flags_o;
  logic [31:0] serial_ch1_event_flags_o, serial_ch2_event_flags_o;
  logic [31:0] capcomp_service_flags_o;
  logic [3:0]  capcomp_req_i;
  logic [1:0]  monitor_pin_i;
  logic [9:0]  fire, pulse, v, acc;
  int          fails, checks_done, i;
  irfb_flag_bank dut (.*);
  irfb_evt_src u_src (.ref_clk_i, .fire_i(fire), .pulse_o(pulse));
  assign {capcomp_req_i, ser2_rx_i, ser2_tx_i, ser2_err_i,
          ser1_rx_i, ser1_tx_i, ser1_err_i} = pulse;
  initial begin
    ref_clk_i = 0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  task close_out;
    $display("checks=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task cmp(input logic [31:0] g, x);
    checks_done++;
    if (g !== x) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, d);
    int n;
    psel_i <= 1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1;
    n = 0;
    do begin @(posedge ref_clk_i); n++; end while (pready_o !== 1'b1 && n < 20);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 0; penable_i <= 0;
    if (n >= 20) begin fails++; close_out; end
    // Idle edge so a following call never reassigns psel_i in one step
    @(posedge ref_clk_i);
  endtask
  task rd_chk(input logic [31:0] a, x);
    apb(0, a, 32'h0);
    cmp(r, x);
  endtask
  function automatic logic [31:0] cc_map(input logic [3:0] q);
    return {11'h0, q[3], 3'h0, q[2], 11'h0, q[1], 3'h0, q[0]};
  endfunction
  task chk_all(input logic [9:0] q);
    rd_chk(32'h0C, {29'h0, q[2:0]});
    rd_chk(32'h10, {29'h0, q[5:3]});
    rd_chk(32'h14, cc_map(q[9:6]));
  endtask
  task pulse_ev(input logic [9:0] q);
    fire <= q;
    @(posedge ref_clk_i);
    fire <= 10'h000;
    repeat (2) @(posedge ref_clk_i);
  endtask
  task clr_all;
    apb(1, 32'h2C, 32'h7);
    apb(1, 32'h30, 32'h7);
    apb(1, 32'h34, 32'h0011_0011);
  endtask
  initial begin
    rst_i = 1; psel_i = 0; penable_i = 0; pwrite_i = 0; paddr_i = 0;
    pwdata_i = 0; monitor_pin_i = 0; fire = 0; fails = 0; checks_done = 0;
    void'($urandom(85430));
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 0;
    @(posedge ref_clk_i);
    for (i = 0; i < 4; i++) rd_chk(32'h08 + 4 * i, 32'h0);
    for (i = 0; i < 10; i++) begin
      pulse_ev(10'h001 << i);
      chk_all(10'h001 << i);
      clr_all;
    end
    acc = 0;
    repeat (12) begin
      v = 10'($urandom);
      pulse_ev(v);
      acc = acc | v;
      chk_all(acc);
    end
    apb(1, 32'h0C, 32'h0);
    cmp({31'h0, e}, 32'h1);
    apb(0, 32'h80, 32'h0);
    cmp(r, 32'h0);
    chk_all(acc);
    clr_all;
    chk_all(10'h000);
    // Transmit event lands on the edge that takes the clear write
    fork
      apb(1, 32'h2C, 32'h7);
      begin
        fire <= 10'h002;
        @(posedge ref_clk_i);
        fire <= 10'h000;
      end
    join
    rd_chk(32'h0C, 32'h2);
    apb(1, 32'h2C, 32'h7);
    monitor_pin_i <= 2'b11;
    repeat (8) @(posedge ref_clk_i);
    monitor_pin_i <= 2'b00;
    repeat (8) @(posedge ref_clk_i);
    rd_chk(32'h08, 32'h0000_03C0);
    apb(1, 32'h28, 32'h0000_03C0);
    rd_chk(32'h08, 32'h0);
    close_out;
  end
endmodule
